// ==== src/wake_pkg.sv ====
`default_nettype none
package wake_pkg;
    // Source index shared by request, enable, interrupt enable and clear operands
    localparam int SRC_PORTS = 0;
    localparam int SRC_TIMER_ONE = 1;
    localparam int SRC_EXTINT = 2;
    localparam int SRC_PREDIV = 3;
    localparam int SRC_TIMER_TWO = 4;
    localparam int SRC_KEYS = 5;
    localparam int SRC_RESFREQ = 6;
    localparam int SRC_COUNT = 7;
    // Switch enable operand bits
    localparam int SW_PORTC_BIT = 4;
    localparam int SW_PORTD_BIT = 3;
    // Stop release enable operand bits
    localparam int STOP_PORTD_BIT = 3;
    localparam int STOP_PORTC_BIT = 4;
    localparam int STOP_EXTINT_BIT = 5;
    localparam int STOP_KEYS_BIT = 7;
    localparam logic [7:0] STOP_ALL_OPERAND = 8'hB0;
    // Status nibble layouts
    localparam int STX_RESFREQ_BIT = 3;
    localparam int STX_TIMER_TWO_BIT = 2;
    localparam int STX_KEYSCAN_BIT = 1;
    localparam int ST4_OVERFLOW_BIT = 2;
    localparam int ST4_WATCHDOG_BIT = 1;
    localparam int ST4_CLOCK_BIT = 0;
    // Reset values
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [SRC_COUNT-1:0] FLAGS_RESET = 7'h00;
    // Chattering filter: cycles a port level must hold before it is believed
    localparam int DEBOUNCE_CYCLES = 16;
    localparam int DEBOUNCE_W = 5;
    // Pins that pass the two-stage synchroniser
    localparam int PIN_W = 17;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_HALT = 2'b01,
        MODE_STOP = 2'b10
    } power_mode_type;
endpackage : wake_pkg
`default_nettype wire

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_out
);
    logic [WIDTH-1:0] first_stage;

    // Two flops; only the second stage is visible to the block
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            first_stage <= '0;
            pins_out <= '0;
        end
        else
        begin
            first_stage <= pins_in;
            pins_out <= first_stage;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ==== src/chatter_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module chatter_filter
    import wake_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic level_in,
    output logic level_out
);
    logic [DEBOUNCE_W-1:0] count;
    logic [DEBOUNCE_W-1:0] next_count;
    logic next_level;

    // Count while the input disagrees; a glitch restarts the wait
    always_comb
    begin
        next_count = '0;
        next_level = level_out;
        if (level_in != level_out)
        begin
            if (count == DEBOUNCE_W'(DEBOUNCE_CYCLES - 1))
                next_level = level_in;
            else
                next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count <= '0;
            level_out <= 1'b0;
        end
        else
        begin
            count <= next_count;
            level_out <= next_level;
        end
    end
endmodule : chatter_filter
`default_nettype wire

// ==== src/halt_stop_wake_flags.sv ====
// Overview of operation
// RL1 - Timer two underflow with its enable sets its wake flag; clear or enable write clears.
// RL2 - Gated converter mode 3 finish with its enable sets the converter wake flag.
// RL3 - Converter wake flag clears when its request or enable is cleared.
// RL4 - Wake status nibble: converter, timer two, keyscan, zero; read copies it out.
// RL5 - Slow instruction clears clock select flag, fast instruction sets it.
// RL6 - Counter overflow sets overflow flag; converter start instruction clears it.
// RL7 - Misc status nibble: zero, overflow, watchdog running, clock select; read copies it.
// RL8 - In stop, high OR of input port c or d pins sets stop wake if enabled.
// RL9 - In stop, high OR of latched keys sets stop wake if key stop enabled.
// RL10 - In stop, any extint edge requests and sets stop wake if enabled.
// RL11 - Stop is refused unless ports a and c are all-input and low; a pending stop wake or extint request enters halt instead.
// RL12 - Stop enable write loads port, extint and key stop enables from operand.
// RL13 - Switch enable write loads port c bit 4 and port d bit 3 enables.
// RL14 - With switch enable, a port input change sets its wake flag and ends halt.
// RL15 - Outside driver keeps other pins of a port low while one pin changes.
// RL16 - Stop and switch enables both set: high port pin releases stop into halt.
// RL17 - Port stop release falls back to stop if the level drops before filtering.
// RL18 - A port wake flag sets the port request; with its enable, interrupt 0 rises.
// RL19 - Once interrupt 0 is accepted it stays blocked until the next switch write.
// RL20 - Halt enable write loads six enables: timers, extint, prediv, keys, converter.
// RL21 - Stop and halt extint enables set: extint change releases stop.
// RL22 - Stop and halt key enables set: high latched keys release stop.
// RL23 - Summary flag is the OR of timer, extint, prediv, key and converter flags.
// RL24 - Stop operand B0 enables key, extint and port c stop release together.
// RL25 - Accepting an interrupt clears its request and its interrupt enable.
// RL26 - All flags run on the system clock and reset to zero.
`timescale 1ns/1ps
`default_nettype none
module halt_stop_wake_flags
    import wake_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] operand_in,
    input wire logic clear_request_instr_in,
    input wire logic halt_enable_write_instr_in,
    input wire logic stop_enable_write_instr_in,
    input wire logic switch_enable_write_instr_in,
    input wire logic irq_enable_write_instr_in,
    input wire logic read_status_x_instr_in,
    input wire logic read_status_four_instr_in,
    input wire logic slow_clock_instr_in,
    input wire logic fast_clock_instr_in,
    input wire logic resfreq_start_instr_in,
    input wire logic halt_instr_in,
    input wire logic stop_instr_in,
    input wire logic [SRC_COUNT-1:0] irq_accept_in,
    input wire logic first_timer_underflow_in,
    input wire logic second_timer_underflow_in,
    input wire logic prediv_overflow_in,
    input wire logic resfreq_finish_in,
    input wire logic resfreq_cap_gated_in,
    input wire logic resfreq_overflow_in,
    input wire logic watchdog_run_in,
    input wire logic extint_pin_in,
    input wire logic [3:0] key_input_pins_in,
    input wire logic [3:0] port_a_pins_in,
    input wire logic [3:0] port_a_input_mode_in,
    input wire logic [3:0] port_c_pins_in,
    input wire logic [3:0] port_c_input_mode_in,
    input wire logic [3:0] port_d_pins_in,
    input wire logic [3:0] port_d_input_mode_in,
    output logic [3:0] status_data_out,
    output logic status_valid_out,
    output logic sysclk_select_flag_out,
    output logic wake_flag_summary_out,
    output logic irq0_out,
    output logic halt_mode_out,
    output logic stop_mode_out
);
    logic [PIN_W-1:0] pins_sync;
    logic extint_sync, extint_prev, extint_edge, key_or;
    logic [3:0] pa_sync, pc_sync, pd_sync;
    logic portc_or, portd_or, portc_clean, portd_clean, portc_prev, portd_prev;
    logic portc_change, portd_change;

    // Only pins cross into this domain; instruction strobes are already local
    pin_sync #(.WIDTH(PIN_W)) u_pin_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pins_in({extint_pin_in, key_input_pins_in, port_a_pins_in, port_c_pins_in, port_d_pins_in}),
        .pins_out(pins_sync)
    );
    assign {extint_sync, pa_sync, pc_sync, pd_sync} = {pins_sync[16], pins_sync[11:0]};
    assign key_or = |pins_sync[15:12];
    // Only input-mode pins take part; OR means one pin at a time may move
    assign portc_or = |(pc_sync & port_c_input_mode_in); // see RL15
    assign portd_or = |(pd_sync & port_d_input_mode_in);

    chatter_filter u_filter_c (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .level_in(portc_or),
        .level_out(portc_clean)
    );
    chatter_filter u_filter_d (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .level_in(portd_or),
        .level_out(portd_clean)
    );
    assign extint_edge = extint_sync ^ extint_prev; // see RL10
    assign portc_change = portc_clean ^ portc_prev;
    assign portd_change = portd_clean ^ portd_prev;

    power_mode_type mode, next_mode;
    logic [SRC_COUNT-1:0] halt_req, next_halt_req, irq_en, next_irq_en, event_vec, clr_vec;
    logic [SRC_COUNT-1:1] halt_en, next_halt_en, wake, next_wake;
    logic stop_en_portc, stop_en_portd, stop_en_extint, stop_en_keys;
    logic next_stop_en_portc, next_stop_en_portd, next_stop_en_extint, next_stop_en_keys;
    logic switch_en_portc, switch_en_portd, next_switch_en_portc, next_switch_en_portd;
    logic wake_flag_portc, wake_flag_portd, next_wake_flag_portc, next_wake_flag_portd;
    logic irq0_block, next_irq0_block, next_irq0;
    logic stop_wake_flag, next_stop_wake_flag, port_fallback, next_port_fallback;
    logic resfreq_overflow_flag, next_resfreq_overflow_flag, next_sysclk;
    logic stop_req_portc, stop_req_portd, stop_req_keys, stop_release, port_release;
    logic stop_pins_ok, halt_release;
    logic [3:0] next_status;
    logic next_status_valid;

    // Enables, requests and wake flags; every set outweighs a same-cycle clear, except that a halt enable write clearing an enable also clears its wake flag
    always_comb
    begin
        next_halt_en = halt_en;
        if (halt_enable_write_instr_in)
            next_halt_en = operand_in[SRC_COUNT-1:1]; // see RL20
        next_irq_en = irq_en & ~irq_accept_in; // see RL25
        if (irq_enable_write_instr_in)
            next_irq_en = operand_in[SRC_COUNT-1:0];
        next_switch_en_portc = switch_en_portc;
        next_switch_en_portd = switch_en_portd;
        if (switch_enable_write_instr_in)
        begin
            next_switch_en_portc = operand_in[SW_PORTC_BIT]; // see RL13
            next_switch_en_portd = operand_in[SW_PORTD_BIT];
        end
        {next_stop_en_keys, next_stop_en_extint, next_stop_en_portc, next_stop_en_portd} =
            {stop_en_keys, stop_en_extint, stop_en_portc, stop_en_portd};
        if (stop_enable_write_instr_in)
        begin
            // Operand B0 enables keys, extint and port c in one write
            next_stop_en_keys = operand_in[STOP_KEYS_BIT]; // see RL12 see RL24
            next_stop_en_extint = operand_in[STOP_EXTINT_BIT];
            next_stop_en_portc = operand_in[STOP_PORTC_BIT];
            next_stop_en_portd = operand_in[STOP_PORTD_BIT];
        end
        // Switch write clears the port flags; a change in the same cycle still lands
        next_wake_flag_portc = (wake_flag_portc & ~switch_enable_write_instr_in)
            | (switch_en_portc & portc_change); // see RL14 see RL16
        next_wake_flag_portd = (wake_flag_portd & ~switch_enable_write_instr_in)
            | (switch_en_portd & portd_change);
        event_vec = '0;
        event_vec[SRC_PORTS] = (next_wake_flag_portc & ~wake_flag_portc)
            | (next_wake_flag_portd & ~wake_flag_portd); // see RL18
        event_vec[SRC_TIMER_ONE] = first_timer_underflow_in;
        event_vec[SRC_EXTINT] = extint_edge;
        event_vec[SRC_PREDIV] = prediv_overflow_in;
        event_vec[SRC_TIMER_TWO] = second_timer_underflow_in;
        event_vec[SRC_KEYS] = key_or;
        event_vec[SRC_RESFREQ] = resfreq_finish_in & resfreq_cap_gated_in; // see RL2
        clr_vec = clear_request_instr_in ? operand_in[SRC_COUNT-1:0] : '0;
        next_halt_req = (halt_req & ~clr_vec & ~irq_accept_in) | event_vec; // see RL25
        // A start-condition flag lives only while request and enable both hold
        next_wake = next_halt_req[SRC_COUNT-1:1] & next_halt_en; // see RL1 see RL3
        next_irq0_block = (irq0_block & ~switch_enable_write_instr_in) | irq_accept_in[SRC_PORTS]; // see RL19
        next_irq0 = next_halt_req[SRC_PORTS] & next_irq_en[SRC_PORTS] & ~next_irq0_block; // see RL18
    end

    // Stop release requests and power mode sequencing
    always_comb
    begin
        stop_req_portc = (mode == MODE_STOP) & portc_or; // see RL8
        stop_req_portd = (mode == MODE_STOP) & portd_or;
        stop_req_keys = (mode == MODE_STOP) & key_or; // see RL9
        next_stop_wake_flag = (stop_wake_flag & ~clear_request_instr_in)
            | (stop_req_portc & stop_en_portc) | (stop_req_portd & stop_en_portd)
            | (stop_req_keys & stop_en_keys)
            | ((mode == MODE_STOP) & extint_edge & stop_en_extint); // see RL10
        port_release = (stop_req_portc & stop_en_portc & switch_en_portc)
            | (stop_req_portd & stop_en_portd & switch_en_portd); // see RL16
        stop_release = port_release
            | ((mode == MODE_STOP) & extint_edge & stop_en_extint & halt_en[SRC_EXTINT]) // see RL21
            | (stop_req_keys & stop_en_keys & halt_en[SRC_KEYS]); // see RL22
        // Stop must not start with a port a or c pin high or driven as output
        stop_pins_ok = (&port_a_input_mode_in) & (&port_c_input_mode_in)
            & ~(|pa_sync) & ~(|pc_sync); // see RL11
        halt_release = (|wake) | wake_flag_portc | wake_flag_portd | halt_req[SRC_PORTS];
        next_mode = mode;
        next_port_fallback = port_fallback & (mode == MODE_HALT);
        unique case (mode)
            MODE_RUN:
            begin
                if (stop_instr_in && stop_pins_ok)
                    next_mode = (stop_wake_flag || halt_req[SRC_EXTINT]) ? MODE_HALT : MODE_STOP;
                else if (halt_instr_in && !halt_release)
                    next_mode = MODE_HALT;
            end
            MODE_HALT:
            begin
                if (halt_release || (|irq_accept_in))
                begin
                    next_mode = MODE_RUN;
                    next_port_fallback = 1'b0;
                end
                else if (port_fallback && !portc_or && !portd_or)
                begin
                    // Pulse too short for the filter: back to sleep
                    next_mode = MODE_STOP; // see RL17
                    next_port_fallback = 1'b0;
                end
            end
            MODE_STOP:
            begin
                if (stop_release)
                begin
                    next_mode = MODE_HALT;
                    next_port_fallback = port_release;
                end
            end
            default:
            begin
                next_mode = MODE_RUN;
                next_port_fallback = 1'b0;
            end
        endcase
    end

    // Status nibbles, clock select and converter overflow
    always_comb
    begin
        next_sysclk = sysclk_select_flag_out;
        if (fast_clock_instr_in)
            next_sysclk = 1'b1; // see RL5
        else if (slow_clock_instr_in)
            next_sysclk = 1'b0;
        // Overflow wins over a start in the same cycle so none is missed
        next_resfreq_overflow_flag = (resfreq_overflow_flag & ~resfreq_start_instr_in)
            | resfreq_overflow_in; // see RL6
        next_status = status_data_out;
        next_status_valid = 1'b0;
        if (read_status_x_instr_in)
        begin
            next_status = STATUS_RESET;
            next_status[STX_RESFREQ_BIT] = wake[SRC_RESFREQ]; // see RL4
            next_status[STX_TIMER_TWO_BIT] = wake[SRC_TIMER_TWO];
            next_status[STX_KEYSCAN_BIT] = wake[SRC_KEYS];
            next_status_valid = 1'b1;
        end
        else if (read_status_four_instr_in)
        begin
            next_status = STATUS_RESET;
            next_status[ST4_OVERFLOW_BIT] = resfreq_overflow_flag; // see RL7
            next_status[ST4_WATCHDOG_BIT] = watchdog_run_in;
            next_status[ST4_CLOCK_BIT] = sysclk_select_flag_out;
            next_status_valid = 1'b1;
        end
    end

    // All state clears to zero on reset
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mode <= MODE_RUN; // see RL26
            halt_req <= FLAGS_RESET;
            irq_en <= FLAGS_RESET;
            halt_en <= '0;
            wake <= '0;
            {stop_en_keys, stop_en_extint, stop_en_portc, stop_en_portd} <= 4'h0;
            {switch_en_portc, switch_en_portd, wake_flag_portc, wake_flag_portd} <= 4'h0;
            {irq0_block, irq0_out, stop_wake_flag, port_fallback} <= 4'h0;
            {extint_prev, portc_prev, portd_prev, resfreq_overflow_flag} <= 4'h0;
            {sysclk_select_flag_out, wake_flag_summary_out, status_valid_out} <= 3'h0;
            {halt_mode_out, stop_mode_out} <= 2'h0;
            status_data_out <= STATUS_RESET;
        end
        else
        begin
            mode <= next_mode;
            halt_req <= next_halt_req;
            irq_en <= next_irq_en;
            halt_en <= next_halt_en;
            wake <= next_wake;
            {stop_en_keys, stop_en_extint, stop_en_portc, stop_en_portd} <=
                {next_stop_en_keys, next_stop_en_extint, next_stop_en_portc, next_stop_en_portd};
            {switch_en_portc, switch_en_portd} <= {next_switch_en_portc, next_switch_en_portd};
            {wake_flag_portc, wake_flag_portd} <= {next_wake_flag_portc, next_wake_flag_portd};
            {irq0_block, irq0_out} <= {next_irq0_block, next_irq0};
            {stop_wake_flag, port_fallback} <= {next_stop_wake_flag, next_port_fallback};
            {extint_prev, portc_prev, portd_prev} <= {extint_sync, portc_clean, portd_clean};
            resfreq_overflow_flag <= next_resfreq_overflow_flag;
            sysclk_select_flag_out <= next_sysclk;
            wake_flag_summary_out <= |next_wake; // see RL23
            status_data_out <= next_status;
            status_valid_out <= next_status_valid;
            halt_mode_out <= (next_mode == MODE_HALT);
            stop_mode_out <= (next_mode == MODE_STOP);
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence accept_then_quiet;
        irq_accept_in[SRC_PORTS] ##1 !switch_enable_write_instr_in [*3];
    endsequence

    a_timer_two_wake: assert property (halt_en[SRC_TIMER_TWO] && second_timer_underflow_in
        && !halt_enable_write_instr_in |=> wake[SRC_TIMER_TWO]) // see RL1
        else $error("timer two wake flag not set");
    a_timer_two_clear: assert property (halt_enable_write_instr_in && !operand_in[SRC_TIMER_TWO]
        |=> !wake[SRC_TIMER_TWO] && !halt_en[SRC_TIMER_TWO]) // see RL1
        else $error("timer two wake flag survived enable clear");
    a_resfreq_wake: assert property (halt_en[SRC_RESFREQ] && resfreq_finish_in && resfreq_cap_gated_in
        && !halt_enable_write_instr_in |=> wake[SRC_RESFREQ] && halt_req[SRC_RESFREQ]) // see RL2
        else $error("converter wake flag not set");
    a_resfreq_clear: assert property (clear_request_instr_in && operand_in[SRC_RESFREQ]
        && !(resfreq_finish_in && resfreq_cap_gated_in) |=> !wake[SRC_RESFREQ]) // see RL3
        else $error("converter wake flag not cleared");
    a_status_x_read: assert property (read_status_x_instr_in |=> status_valid_out
        && status_data_out == {$past(wake[SRC_RESFREQ]), $past(wake[SRC_TIMER_TWO]),
        $past(wake[SRC_KEYS]), 1'b0}) // see RL4
        else $error("wake status nibble wrong");
    a_clock_fast: assert property (fast_clock_instr_in |=> sysclk_select_flag_out) // see RL5
        else $error("clock select not set by fast instruction");
    a_overflow_clear: assert property (resfreq_start_instr_in && !resfreq_overflow_in
        |=> !resfreq_overflow_flag) // see RL6
        else $error("overflow flag not cleared by start");
    a_stop_refused: assert property (mode == MODE_RUN && stop_instr_in && (|pc_sync)
        |=> !stop_mode_out) // see RL11
        else $error("stop entered with port c high");
    a_irq_blocked: assert property (accept_then_quiet |-> !irq0_out) // see RL19
        else $error("interrupt 0 raised while blocked");
    a_summary_flag: assert property (wake_flag_summary_out == (|wake)) // see RL23
        else $error("summary flag mismatch");
endmodule : halt_stop_wake_flags
`default_nettype wire

// ==== test/pin_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side pins: one port c pin high at a time, and the external interrupt line
module pin_source_model (
    input wire logic clock_in,
    input wire logic [1:0] pin_sel_in,
    input wire logic raise_in,
    input wire logic extint_level_in,
    output logic [3:0] port_c_pins_out,
    output logic extint_pin_out
);
    // Other port pins stay low so the OR sees only the chosen pin
    always_ff @(posedge clock_in)
    begin
        port_c_pins_out <= raise_in ? (4'h1 << pin_sel_in) : 4'h0;
        extint_pin_out <= extint_level_in;
    end
endmodule : pin_source_model
`default_nettype wire

// ==== test/halt_stop_wake_flags_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("Error at %0t: got %h exp %h", $time, a, b); end end
module halt_stop_wake_flags_test;
    import wake_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] op = 8'h00;
    logic [11:0] instr = 12'h000;
    logic [4:0] ev = 5'h00;
    logic [SRC_COUNT-1:0] accept = '0;
    logic wd_run = 1'b1;
    logic gated = 1'b1;
    logic [1:0] pin_sel = 2'h0;
    logic raise = 1'b0;
    logic ext_level = 1'b0;
    logic [3:0] quiet = 4'h0;
    logic [3:0] all_in = 4'hF;
    logic [3:0] pc_pins, st_data;
    logic ext_pin, st_valid, clk_sel, summary, irq0, halt_mode, stop_mode;
    int errors = 0;
    int checks = 0;
    // Strobe positions inside instr
    localparam int CLR = 0, HEN = 1, SEN = 2, SWE = 3, IEN = 4, RDX = 5, RD4 = 6, SLW = 7, FST = 8, RFS = 9, STP = 11;
    always #10 clock_in = ~clock_in;
    pin_source_model i_pin_source_model (.clock_in(clock_in), .pin_sel_in(pin_sel), .raise_in(raise),
        .extint_level_in(ext_level), .port_c_pins_out(pc_pins), .extint_pin_out(ext_pin));
    halt_stop_wake_flags i_halt_stop_wake_flags (.clock_in(clock_in), .rst_n_in(rst_n_in), .operand_in(op),
        .clear_request_instr_in(instr[CLR]), .halt_enable_write_instr_in(instr[HEN]),
        .stop_enable_write_instr_in(instr[SEN]), .switch_enable_write_instr_in(instr[SWE]),
        .irq_enable_write_instr_in(instr[IEN]), .read_status_x_instr_in(instr[RDX]),
        .read_status_four_instr_in(instr[RD4]), .slow_clock_instr_in(instr[SLW]), .fast_clock_instr_in(instr[FST]),
        .resfreq_start_instr_in(instr[RFS]), .halt_instr_in(instr[10]), .stop_instr_in(instr[STP]),
        .irq_accept_in(accept), .first_timer_underflow_in(ev[0]), .second_timer_underflow_in(ev[1]),
        .prediv_overflow_in(ev[2]), .resfreq_finish_in(ev[3]), .resfreq_cap_gated_in(gated),
        .resfreq_overflow_in(ev[4]), .watchdog_run_in(wd_run), .extint_pin_in(ext_pin),
        .key_input_pins_in(quiet), .port_a_pins_in(quiet), .port_a_input_mode_in(all_in),
        .port_c_pins_in(pc_pins), .port_c_input_mode_in(all_in), .port_d_pins_in(quiet),
        .port_d_input_mode_in(all_in), .status_data_out(st_data), .status_valid_out(st_valid),
        .sysclk_select_flag_out(clk_sel), .wake_flag_summary_out(summary), .irq0_out(irq0),
        .halt_mode_out(halt_mode), .stop_mode_out(stop_mode));
    // One strobe cycle; returns on the edge that takes it
    task automatic issue(input int k, input logic [7:0] v);
        @(posedge clock_in);
        instr[k] <= 1'b1;
        op <= v;
        @(posedge clock_in);
        instr[k] <= 1'b0;
    endtask : issue
    task automatic pulse(input int k);
        @(posedge clock_in);
        ev[k] <= 1'b1;
        @(posedge clock_in);
        ev[k] <= 1'b0;
    endtask : pulse
    // Step past the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : settle
    task automatic read_check(input int k, input logic [3:0] exp);
        issue(k, 8'h00);
        #1;
        `CHK(st_valid, 1'b1)
        `CHK(st_data, exp)
    endtask : read_check
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Watchdog at 3000 cycles, well beyond the under two hundred cycles the sequence needs
    initial
    begin
        #(20 * 3000);
        errors++;
        final_report();
    end
    initial
    begin
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        read_check(RDX, STATUS_RESET);
        read_check(RD4, 4'h2);
        `CHK(clk_sel, 1'b0)
        $display("Test reset done");
        issue(HEN, 8'h10);
        pulse(1);
        settle(1);
        read_check(RDX, 4'h4);
        `CHK(summary, 1'b1)
        issue(CLR, 8'h10);
        settle(1);
        read_check(RDX, 4'h0);
        `CHK(summary, 1'b0)
        $display("Test timer two done");
        issue(HEN, 8'h40);
        @(posedge clock_in) gated <= 1'b0;
        pulse(3);
        settle(1);
        read_check(RDX, 4'h0);
        @(posedge clock_in) gated <= 1'b1;
        pulse(3);
        settle(1);
        read_check(RDX, 4'h8);
        issue(HEN, 8'h00);
        settle(1);
        read_check(RDX, 4'h0);
        $display("Test converter done");
        issue(FST, 8'h00);
        settle(1);
        `CHK(clk_sel, 1'b1)
        pulse(4);
        settle(1);
        read_check(RD4, 4'h7);
        issue(RFS, 8'h00);
        issue(SLW, 8'h00);
        settle(1);
        read_check(RD4, 4'h2);
        @(posedge clock_in) wd_run <= 1'b0;
        read_check(RD4, 4'h0);
        $display("Test misc status done");
        issue(HEN, 8'h10);
        issue(10, 8'h00);
        settle(1);
        `CHK(halt_mode, 1'b1)
        pulse(1);
        settle(1);
        `CHK(halt_mode, 1'b0)
        $display("Test halt done");
        issue(SEN, STOP_ALL_OPERAND);
        issue(HEN, 8'h24);
        issue(CLR, 8'h7F);
        issue(STP, 8'h00);
        settle(2);
        `CHK(stop_mode, 1'b1)
        @(posedge clock_in) ext_level <= 1'b1;
        settle(8);
        `CHK(stop_mode, 1'b0)
        `CHK(summary, 1'b1)
        $display("Test stop release done");
        issue(CLR, 8'h7F);
        issue(SWE, 8'h10);
        issue(IEN, 8'h01);
        @(posedge clock_in) raise <= 1'b1;
        pin_sel <= 2'h2;
        for (int i = 0; i < 40 && irq0 !== 1'b1; i++) @(posedge clock_in);
        settle(1);
        `CHK(irq0, 1'b1)
        issue(STP, 8'h00);
        settle(2);
        `CHK(stop_mode, 1'b0)
        @(posedge clock_in) accept[0] <= 1'b1;
        @(posedge clock_in) accept <= '0;
        settle(2);
        `CHK(irq0, 1'b0)
        issue(IEN, 8'h01);
        settle(2);
        `CHK(irq0, 1'b0)
        issue(SWE, 8'h10);
        @(posedge clock_in) raise <= 1'b0;
        for (int j = 0; j < 40 && irq0 !== 1'b1; j++) @(posedge clock_in);
        settle(1);
        `CHK(irq0, 1'b1)
        $display("Test port wake done");
        final_report();
    end
endmodule : halt_stop_wake_flags_test
`default_nettype wire
